// ### verilog/cpw_top.sv
// PWM unit with output steering: standard PWM channel, enhanced
// capture/compare/PWM channel, shared base timer, APB registers.
// Assumes an APB master on clock; capture_in is asynchronous;
// wide_timer and conv_enable come from logic on the same clock.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module cpw_top
   import cpw_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] wide_timer,
   input wire logic conv_enable,
   input wire logic capture_in,
   output logic wave_pin,
   output logic wave_pin_own,
   output cpw_pins_s enh_pins,
   output logic wide_timer_reset,
   output logic conv_start
);
   cpw_state_s s_q;
   cpw_state_s s_d;
   cpw_tb_s tb;
   logic wr;
   logic [31:0] rdv;
   logic pwm_std;
   logic pwm_enh;
   logic std_match;
   logic enh_match;
   logic new_match;
   logic rise;
   logic fall;
   logic cap_ev;
   logic [3:0] mode;
   logic [3:0] pol;

   function automatic logic cpw_hit(input logic [7:0] a);
      return a inside {CPW_OFF_BASE, CPW_OFF_PERIOD, CPW_OFF_TCTL,
         CPW_OFF_DUTY, CPW_OFF_SHADOW, CPW_OFF_UCON, CPW_OFF_EDUTY,
         CPW_OFF_ESHADOW, CPW_OFF_ECON, CPW_OFF_STATUS};
   endfunction

   // One timer for both channels
   cpw_timebase u_timebase (
      .clock(clock),
      .rst_b(rst_b),
      .period_limit(s_q.period),
      .timer_ctl(s_q.tctl),
      .cnt_wr(wr && (paddr == CPW_OFF_BASE)),
      .cnt_wdata(pwdata[7:0]),
      .tb(tb)
   );

   assign wr = psel && penable && pwrite && cpw_hit(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !cpw_hit(paddr);
   assign prdata = s_q.rdata;
   assign wave_pin = s_q.wave;
   assign wave_pin_own = s_q.wown;
   assign enh_pins.val = s_q.out;
   assign enh_pins.own = s_q.own;
   assign wide_timer_reset = s_q.trig;
   assign conv_start = s_q.conv;

   always_comb begin
      case (paddr)
         CPW_OFF_BASE: rdv = {24'h000000, tb.base};
         CPW_OFF_PERIOD: rdv = {24'h000000, s_q.period};
         CPW_OFF_TCTL: rdv = {24'h000000, s_q.tctl};
         CPW_OFF_DUTY: rdv = {24'h000000, s_q.duty_hi};
         CPW_OFF_SHADOW: rdv = {24'h000000, s_q.shadow};
         CPW_OFF_UCON: rdv = {26'h0000000, s_q.ucon};
         CPW_OFF_EDUTY: rdv = {24'h000000, s_q.enh_hi};
         CPW_OFF_ESHADOW: rdv = {24'h000000, s_q.enh_sh};
         CPW_OFF_ECON: rdv = {24'h000000, s_q.econ};
         CPW_OFF_STATUS: rdv = {31'h00000000, s_q.flag};
         default: rdv = 32'h00000000;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.trig = 1'b0;
      s_d.conv = 1'b0;
      cap_ev = 1'b0;
      // Read data captured in the setup phase
      if (psel && !penable) begin
         s_d.rdata = rdv;
      end
      if (wr) begin
         case (paddr)
            CPW_OFF_PERIOD: s_d.period = pwdata[7:0];
            CPW_OFF_TCTL: s_d.tctl = pwdata[7:0] & CPW_TCTL_MASK;
            CPW_OFF_DUTY: s_d.duty_hi = pwdata[7:0];
            CPW_OFF_SHADOW: begin
               if (!cpw_is_pwm(s_q.ucon[3:0])) begin
                  s_d.shadow = pwdata[7:0];
               end
            end
            CPW_OFF_UCON: s_d.ucon = pwdata[5:0];
            CPW_OFF_EDUTY: s_d.enh_hi = pwdata[7:0];
            CPW_OFF_ESHADOW: begin
               if (!cpw_is_pwm(s_q.econ[3:0])) begin
                  s_d.enh_sh = pwdata[7:0];
               end
            end
            CPW_OFF_ECON: begin
               s_d.econ = pwdata[7:0];
               // Compare set/clear modes start from the opposite level
               if (pwdata[3:0] == CPW_M_SET) begin
                  s_d.cmp = 1'b0;
               end else if (pwdata[3:0] == CPW_M_CLR) begin
                  s_d.cmp = 1'b1;
               end
            end
            CPW_OFF_STATUS: begin
               if (pwdata[0]) begin
                  s_d.flag = 1'b0;
               end
            end
            default: s_d.rdata = s_d.rdata;
         endcase
      end

      // Standard channel
      pwm_std = cpw_is_pwm(s_d.ucon[3:0]);
      std_match = {s_q.shadow, s_q.lat} == {tb.base, tb.frac};
      s_d.wown = pwm_std;
      if (!pwm_std) begin
         s_d.wave = 1'b0;
      end else if (tb.wrap) begin
         s_d.shadow = s_q.duty_hi;
         s_d.lat = s_q.ucon[CPW_DC_LO +: 2];
         s_d.wave = {s_q.duty_hi, s_q.ucon[CPW_DC_LO +: 2]} != 10'h000;
      end else if (std_match) begin
         // A duty past the period never matches and stays high
         s_d.wave = 1'b0;
      end

      // Enhanced channel, same boundary as the standard one
      mode = s_d.econ[3:0];
      pwm_enh = cpw_is_pwm(mode);
      enh_match = {s_q.enh_sh, s_q.elat} == {tb.base, tb.frac};
      if (!pwm_enh) begin
         s_d.ewave = 1'b0;
      end else if (tb.wrap) begin
         s_d.enh_sh = s_q.enh_hi;
         s_d.elat = s_q.econ[CPW_DC_LO +: 2];
         s_d.ewave = {s_q.enh_hi, s_q.econ[CPW_DC_LO +: 2]} != 10'h000;
      end else if (enh_match) begin
         s_d.ewave = 1'b0;
      end
      if (mode == CPW_M_OFF) begin
         s_d.cmp = 1'b0;
      end

      // Compare against the wide timer, acting on the first match cycle
      s_d.mt = {s_q.enh_sh, s_q.enh_hi} == wide_timer;
      new_match = s_d.mt && !s_q.mt;
      if (cpw_is_cmp(mode) && new_match) begin
         s_d.flag = 1'b1;
         case (mode)
            CPW_M_TOG: s_d.cmp = !s_q.cmp;
            CPW_M_SET: s_d.cmp = 1'b1;
            CPW_M_CLR: s_d.cmp = 1'b0;
            CPW_M_TRIG: begin
               s_d.trig = 1'b1;
               s_d.conv = conv_enable;
            end
            default: s_d.cmp = s_d.cmp;
         endcase
      end

      // Capture input: two-stage sync, then edge detect
      s_d.sync = {s_q.sync[1:0], capture_in};
      rise = s_q.sync[1] && !s_q.sync[2];
      fall = !s_q.sync[1] && s_q.sync[2];
      if (!cpw_is_cap(mode)) begin
         s_d.cap_cnt = 4'h0;
      end else begin
         case (mode)
            CPW_M_FALL: cap_ev = fall;
            CPW_M_RISE: cap_ev = rise;
            CPW_M_RISE4: cap_ev = rise && (s_q.cap_cnt == CPW_CAP4_LAST);
            default: cap_ev = rise && (s_q.cap_cnt == CPW_CAP16_LAST);
         endcase
         if (rise) begin
            s_d.cap_cnt = cap_ev ? 4'h0 : s_q.cap_cnt + 4'h1;
         end
         if (cap_ev) begin
            {s_d.enh_sh, s_d.enh_hi} = wide_timer;
            s_d.flag = 1'b1;
         end
      end

      // Output steering and polarity
      s_d.out = 4'h0;
      s_d.own = 4'h0;
      if (pwm_enh) begin
         case (cpw_steer_e'(s_d.econ[CPW_STEER_LO +: 2]))
            CPW_SINGLE: begin
               s_d.out = {3'b000, s_d.ewave};
               s_d.own = 4'b0001;
            end
            CPW_FWD: begin
               s_d.out = {s_d.ewave, 2'b00, 1'b1};
               s_d.own = 4'b1111;
            end
            CPW_HALF: begin
               s_d.out = {2'b00, !s_d.ewave, s_d.ewave};
               s_d.own = 4'b0011;
            end
            default: begin
               s_d.out = {1'b0, 1'b1, s_d.ewave, 1'b0};
               s_d.own = 4'b1111;
            end
         endcase
         // Bit 1 inverts A/C, bit 0 inverts B/D
         pol = {s_d.econ[0], s_d.econ[1], s_d.econ[0], s_d.econ[1]};
         s_d.out = (s_d.out ^ pol) & s_d.own;
      end else begin
         pol = 4'h0;
         if (cpw_is_cmp(mode)) begin
            // Steering field ignored; only A is driven
            s_d.out = {3'b000, s_d.cmp};
            s_d.own = 4'b0001;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= CPW_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   period_wrap_a: assert property (
      tb.wrap |-> tb.base == 8'h00)
      else $error("Counter did not clear after period match");

   shadow_load_a: assert property (
      tb.wrap && pwm_std |=> s_q.shadow == $past(s_q.duty_hi)
         && s_q.lat == $past(s_q.ucon[5:4]))
      else $error("Duty not buffered at boundary");

   shadow_hold_a: assert property (
      pwm_std && !tb.wrap |=> $stable(s_q.shadow))
      else $error("Shadow changed inside a period");

   wave_start_a: assert property (
      tb.wrap && pwm_std && {s_q.duty_hi, s_q.ucon[5:4]} != 10'h000
         |=> s_q.wave)
      else $error("Pin not set at period start");

   zero_duty_a: assert property (
      tb.wrap && pwm_std && {s_q.duty_hi, s_q.ucon[5:4]} == 10'h000
         |=> !s_q.wave)
      else $error("Pin set with zero duty");

   duty_match_a: assert property (
      pwm_std && !tb.wrap && std_match |=> !s_q.wave)
      else $error("Pin not cleared on duty match");

   over_high_a: assert property (
      pwm_std && !tb.wrap && s_q.wave
         && {s_q.shadow, s_q.lat} > {s_q.period, 2'b11} |=> s_q.wave)
      else $error("Pin cleared with duty past period");

   off_clear_a: assert property (
      !pwm_std |=> !s_q.wave && !s_q.wown)
      else $error("Output latch not low with unit off");

   steer_ignore_a: assert property (
      !cpw_is_pwm(s_q.econ[3:0]) |-> enh_pins.own[3:1] == 3'b000)
      else $error("Pins B to D held outside PWM");

   cmp_flag_a: assert property (
      cpw_is_cmp(mode) && new_match |=> s_q.flag)
      else $error("Event flag not set on compare match");

   trig_pulse_a: assert property (
      mode == CPW_M_TRIG && new_match
         |=> wide_timer_reset ##1 !wide_timer_reset)
      else $error("Special trigger not a one-cycle pulse");

   polarity_a: assert property (
      cpw_is_pwm(s_q.econ[3:0]) && s_q.econ[7:6] == 2'b00
         |-> enh_pins.val[0] == (s_q.ewave ^ s_q.econ[1]))
      else $error("Single output polarity wrong");

   shared_load_a: assert property (
      tb.wrap && pwm_enh |=> s_q.enh_sh == $past(s_q.enh_hi))
      else $error("Enhanced duty missed shared boundary");

endmodule // cpw_top

// ### verilog/cpw_pkg.sv
// Package for the PWM unit with output steering: offsets, fields,
// mode codes, carrier structs and state types.
// Assumes a 32-bit APB register bus with byte addresses.
package cpw_pkg;

   // Register byte offsets
   localparam logic [7:0] CPW_OFF_BASE = 8'h00;
   localparam logic [7:0] CPW_OFF_PERIOD = 8'h04;
   localparam logic [7:0] CPW_OFF_TCTL = 8'h08;
   localparam logic [7:0] CPW_OFF_DUTY = 8'h0c;
   localparam logic [7:0] CPW_OFF_SHADOW = 8'h10;
   localparam logic [7:0] CPW_OFF_UCON = 8'h14;
   localparam logic [7:0] CPW_OFF_EDUTY = 8'h18;
   localparam logic [7:0] CPW_OFF_ESHADOW = 8'h1c;
   localparam logic [7:0] CPW_OFF_ECON = 8'h20;
   localparam logic [7:0] CPW_OFF_STATUS = 8'h24;

   // Reset values, write mask and field positions
   localparam logic [7:0] CPW_RST_PERIOD = 8'hff;
   localparam logic [7:0] CPW_TCTL_MASK = 8'h7f;
   localparam int CPW_TCTL_ON = 2;
   localparam int CPW_TCTL_PS = 0;
   localparam int CPW_DC_LO = 4;
   localparam int CPW_STEER_LO = 6;

   // Prescaler: last count of one increment cycle, 4 phases times factor; capture: last rising edge counted
   localparam logic [5:0] CPW_PRE_LAST1 = 6'h03;
   localparam logic [5:0] CPW_PRE_LAST4 = 6'h0f;
   localparam logic [5:0] CPW_PRE_LAST16 = 6'h3f;
   localparam logic [3:0] CPW_CAP4_LAST = 4'h3;
   localparam logic [3:0] CPW_CAP16_LAST = 4'hf;

   // Mode codes
   localparam logic [3:0] CPW_M_OFF = 4'h0;
   localparam logic [3:0] CPW_M_TOG = 4'h2;
   localparam logic [3:0] CPW_M_FALL = 4'h4;
   localparam logic [3:0] CPW_M_RISE = 4'h5;
   localparam logic [3:0] CPW_M_RISE4 = 4'h6;
   localparam logic [3:0] CPW_M_RISE16 = 4'h7;
   localparam logic [3:0] CPW_M_SET = 4'h8;
   localparam logic [3:0] CPW_M_CLR = 4'h9;
   localparam logic [3:0] CPW_M_SOFT = 4'ha;
   localparam logic [3:0] CPW_M_TRIG = 4'hb;

   typedef enum logic [1:0] {
      CPW_SINGLE = 2'b00,
      CPW_FWD = 2'b01,
      CPW_HALF = 2'b10,
      CPW_REV = 2'b11
   } cpw_steer_e;

   typedef struct packed {
      logic [7:0] base;
      logic [1:0] frac;
      logic wrap;
   } cpw_tb_s;

   typedef struct packed {
      logic [3:0] val;
      logic [3:0] own;
   } cpw_pins_s;

   typedef struct packed {
      logic [7:0] base;
      logic [5:0] pre;
   } cpw_tbst_s;

   typedef struct packed {
      logic [7:0] period;
      logic [7:0] tctl;
      logic [7:0] duty_hi;
      logic [7:0] shadow;
      logic [5:0] ucon;
      logic [1:0] lat;
      logic [7:0] enh_hi;
      logic [7:0] enh_sh;
      logic [7:0] econ;
      logic [1:0] elat;
      logic flag;
      logic wave;
      logic wown;
      logic ewave;
      logic cmp;
      logic mt;
      logic [2:0] sync;
      logic [3:0] cap_cnt;
      logic [31:0] rdata;
      logic trig;
      logic conv;
      logic [3:0] out;
      logic [3:0] own;
   } cpw_state_s;

   localparam cpw_state_s CPW_STATE_RST = '{period: CPW_RST_PERIOD, default: '0};

   function automatic logic cpw_is_pwm(input logic [3:0] m);
      return m[3:2] == 2'b11;
   endfunction

   function automatic logic cpw_is_cmp(input logic [3:0] m);
      return (m == CPW_M_TOG) || (m[3:2] == 2'b10);
   endfunction

   function automatic logic cpw_is_cap(input logic [3:0] m);
      return m[3:2] == 2'b01;
   endfunction

endpackage

// ### verilog/cpw_timebase.sv
// Shared base timer: prescaler, quarter phases, 8-bit counter, wrap.
// Assumes controls come from registers on the same clock.
`timescale 1ns/1ps
module cpw_timebase
   import cpw_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] period_limit,
   input wire logic [7:0] timer_ctl,
   input wire logic cnt_wr,
   input wire logic [7:0] cnt_wdata,
   output cpw_tb_s tb
);
   cpw_tbst_s s_q;
   cpw_tbst_s s_d;
   logic [5:0] last;
   logic tick;

   always_comb begin
      case (timer_ctl[CPW_TCTL_PS +: 2])
         2'b00: last = CPW_PRE_LAST1;
         2'b01: last = CPW_PRE_LAST4;
         default: last = CPW_PRE_LAST16;
      endcase
      // One increment per four phases times the factor
      tick = timer_ctl[CPW_TCTL_ON] && (s_q.pre == last);
      s_d = s_q;
      if (cnt_wr) begin
         s_d.base = cnt_wdata;
         s_d.pre = 6'h00;
      end else if (timer_ctl[CPW_TCTL_ON]) begin
         if (tick) begin
            s_d.pre = 6'h00;
            if (s_q.base == period_limit) begin
               s_d.base = 8'h00;
            end else begin
               s_d.base = s_q.base + 8'h01;
            end
         end else begin
            s_d.pre = s_q.pre + 6'h01;
         end
      end
      // Next count, so registered pins change on the matching count
      tb.base = s_d.base;
      case (timer_ctl[CPW_TCTL_PS +: 2])
         2'b00: tb.frac = s_d.pre[1:0];
         2'b01: tb.frac = s_d.pre[3:2];
         default: tb.frac = s_d.pre[5:4];
      endcase
      tb.wrap = tick && (s_q.base == period_limit) && !cnt_wr;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // cpw_timebase

// ### test/cpw_load.sv
// Load model on the unit's output pins.
// Assumes pin levels and ownership are registered on the system clock.
`timescale 1ns/1ps
module cpw_load
   import cpw_pkg::*;
(
   input wire logic wave_pin,
   input wire logic wave_pin_own,
   input wire cpw_pins_s enh_pins,
   output logic [4:0] lvl
);
   // Released pins fall to the pull-down level
   assign lvl[4] = wave_pin_own ? wave_pin : 1'b0;
   assign lvl[3:0] = enh_pins.val & enh_pins.own;
endmodule // cpw_load

// ### test/ccp_pwm_with_output_steering_tb.sv
// Self-checking bench for the PWM unit: APB register tasks, pin counts.
// Assumes cpw_top with zero-wait APB and the load model on its pins.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ccp_pwm_with_output_steering_tb
   import cpw_pkg::*;
;
   logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic conv_enable = 0, capture_in = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [15:0] wide_timer = '0;
   logic pready, pslverr, wave_pin, wave_pin_own, wide_timer_reset, conv_start, err;
   logic [3:0] oe;
   logic [4:0] lvl, prv;
   cpw_pins_s enh_pins;
   int n_mismatch = 0, tests_run = 0, cyc = 0, n_tr = 0, n_cv = 0, t0, c0, x;
   int hi[5], rs[5];
   int sp[8] = '{0, 0, 0, 0, 0, 1, 3, 2};
   int pr[8] = '{3, 3, 3, 3, 3, 1, 0, 0};
   int dt[8] = '{5, 0, 15, 16, 1023, 6, 3, 2};
   int eh[8] = '{40, 0, 120, 128, 128, 96, 96, 64};
   int er[8] = '{8, 0, 8, 0, 0, 4, 2, 2};
   // Pin kinds A..D: 0 inactive, 1 modulated, 2 active, 3 complement
   int kd[4][4] = '{'{1, 0, 0, 0}, '{2, 0, 0, 1}, '{1, 3, 0, 0}, '{0, 1, 2, 0}};
   int cm[6] = '{8, 9, 2, 10, 11, 11};
   int cpre[6] = '{0, 1, 0, 0, 0, 0};
   int cpost[6] = '{1, 0, 1, 0, 0, 0};
   int km[4] = '{4, 5, 6, 7};
   int kn[4] = '{1, 1, 4, 16};

   cpw_top cpw_top_inst (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .wide_timer, .conv_enable, .capture_in, .wave_pin,
      .wave_pin_own, .enh_pins, .wide_timer_reset, .conv_start);
   cpw_load cpw_load_inst (.wave_pin, .wave_pin_own, .enh_pins, .lvl);

   always #4 clock = ~clock;

   always @(posedge clock) begin
      cyc++;
      n_tr += wide_timer_reset;
      n_cv += conv_start;
      if (cyc == 40000) begin
         n_mismatch++;
         summarize();
      end
   end

   task summarize();
      $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock) penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, '0);
      `CHK(rd, e)
   endtask

   // Counts high cycles and rising edges on every load pin
   task meas(input int w);
      hi = '{default: 0};
      rs = '{default: 0};
      prv = lvl;
      repeat (w) begin
         @(posedge clock);
         for (int i = 0; i < 5; i++) begin
            hi[i] += lvl[i];
            rs[i] += (lvl[i] && !prv[i]);
         end
         prv = lvl;
      end
   endtask

   task pulse();
      capture_in <= 1'b1;
      repeat (6) @(posedge clock);
      capture_in <= 1'b0;
      repeat (6) @(posedge clock);
   endtask

   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      // Reset values, then an unmapped place
      for (int i = 0; i < 10; i++) rdchk(8'(i * 4), (i == 1) ? 32'hff : 32'h0);
      apb(1'b0, 8'h40, '0);
      `CHK({err, rd}, 33'h100000000)
      apb(1'b1, 8'h40, 32'hff);
      `CHK(err, 1'b1)
      wr(CPW_OFF_TCTL, 32'hff);
      rdchk(CPW_OFF_TCTL, 32'h7f);
      // Shadow holds until a period boundary
      wr(CPW_OFF_TCTL, 32'h0);
      wr(CPW_OFF_PERIOD, 32'h3);
      wr(CPW_OFF_DUTY, 32'h1);
      wr(CPW_OFF_UCON, 32'h2c);
      rdchk(CPW_OFF_SHADOW, 32'h0);
      wr(CPW_OFF_BASE, 32'h0);
      wr(CPW_OFF_TCTL, 32'h4);
      repeat (40) @(posedge clock);
      rdchk(CPW_OFF_SHADOW, 32'h1);
      wr(CPW_OFF_SHADOW, 32'h55);
      rdchk(CPW_OFF_SHADOW, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(CPW_OFF_TCTL, 32'h0);
         wr(CPW_OFF_PERIOD, 32'(pr[i]));
         wr(CPW_OFF_DUTY, 32'(dt[i] >> 2));
         wr(CPW_OFF_UCON, 32'((dt[i] & 3) << 4));
         wr(CPW_OFF_BASE, 32'h0);
         wr(CPW_OFF_TCTL, 32'(4 + sp[i]));
         wr(CPW_OFF_UCON, 32'(((dt[i] & 3) << 4) + 12));
         repeat (200) @(posedge clock);
         meas(128);
         `CHK(hi[4], eh[i])
         `CHK(rs[4], er[i])
      end
      wr(CPW_OFF_UCON, 32'h0);
      `CHK({wave_pin, wave_pin_own}, 2'b00)
      // Steering and polarity, both channels at duty 6 of 16
      wr(CPW_OFF_TCTL, 32'h0);
      wr(CPW_OFF_PERIOD, 32'h3);
      wr(CPW_OFF_DUTY, 32'h1);
      wr(CPW_OFF_EDUTY, 32'h1);
      wr(CPW_OFF_BASE, 32'h0);
      wr(CPW_OFF_TCTL, 32'h4);
      wr(CPW_OFF_UCON, 32'h2c);
      for (int s = 0; s < 4; s++) begin
         for (int p = 0; p < 4; p++) begin
            wr(CPW_OFF_ECON, {24'h0, s[1:0], 4'hb, p[1:0]});
            repeat (100) @(posedge clock);
            meas(128);
            oe = (s == 0) ? 4'h1 : (s == 2) ? 4'h3 : 4'hf;
            `CHK(enh_pins.own, oe)
            `CHK({hi[4], rs[4], rs[0]}, {32'd48, 32'd8, s[0] ? 32'd0 : 32'd8})
            for (int i = 0; i < 4; i++) begin
               if (oe[i]) begin
                  x = (kd[s][i] == 0) ? 0 : (kd[s][i] == 1) ? 48 : (kd[s][i] == 2) ? 128 : 80;
                  if ((i % 2 == 0) ? p[1] : p[0]) x = 128 - x;
                  `CHK(hi[i], x)
               end
            end
         end
      end
      // Non-PWM modes release B, C and D whatever the steering says
      for (int m = 0; m < 12; m++) begin
         wr(CPW_OFF_ECON, {24'h0, 4'hc, m[3:0]});
         `CHK(enh_pins.own[3:1], 3'b000)
         if (m == 1 || m == 3) `CHK(enh_pins.own, 4'h0)
      end
      wr(CPW_OFF_EDUTY, 32'h34);
      wr(CPW_OFF_ESHADOW, 32'h12);
      for (int i = 0; i < 6; i++) begin
         conv_enable <= (i == 4);
         wr(CPW_OFF_ECON, 32'h0);
         wr(CPW_OFF_ECON, 32'(cm[i]));
         wr(CPW_OFF_STATUS, 32'h1);
         `CHK(enh_pins.val[0], cpre[i][0])
         t0 = n_tr;
         c0 = n_cv;
         wide_timer <= 16'h1234;
         repeat (6) @(posedge clock);
         `CHK(enh_pins.val[0], cpost[i][0])
         `CHK({n_tr - t0, n_cv - c0}, {32'(i >= 4), 32'(i == 4)})
         rdchk(CPW_OFF_STATUS, 32'h1);
         wide_timer <= 16'h0;
      end
      for (int i = 0; i < 4; i++) begin
         wr(CPW_OFF_ECON, 32'h0);
         wr(CPW_OFF_ECON, 32'(km[i]));
         wide_timer <= 16'h0a00 + 16'(km[i]);
         wr(CPW_OFF_STATUS, 32'h1);
         repeat (kn[i] - 1) pulse();
         rdchk(CPW_OFF_STATUS, 32'h0);
         pulse();
         rdchk(CPW_OFF_STATUS, 32'h1);
         rdchk(CPW_OFF_EDUTY, 32'(km[i]));
         rdchk(CPW_OFF_ESHADOW, 32'h0a);
      end
      summarize();
   end
endmodule // ccp_pwm_with_output_steering_tb
